// File: dv/rmii_mac_model.sv
// mac end model: drives the transmit pins and decodes received nibbles
// assumes: refClk is the free-running link clock; receive decode is 100 Mb/s only
module rmii_mac_model (
    input wire logic refClk,
    output logic txEn,
    output logic [1:0] txd,
    input wire logic [1:0] rxd,
    input wire logic crsDv,
    input wire logic rxEr,
    output logic gotValid,
    output logic [4:0] gotNib
);
    timeunit 1ns;
    timeprecision 100ps;
    logic inFrame = 1'b0;
    logic started = 1'b0;
    logic half = 1'b0;
    logic prevDv = 1'b0;
    logic [1:0] low = 2'h0;

    initial begin
        txEn = 1'b0;
        txd = 2'h0;
        gotValid = 1'b0;
        gotNib = 5'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // each di-bit stands hold cycles; a nonzero idleVal probes the device
    task automatic send_frame(input logic [3:0] nibs[$], input int hold,
                              input logic [1:0] idleVal);
        foreach (nibs[i]) begin
            for (int k = 0; k < 2 * hold; k++) begin
                @(posedge refClk);
                txEn <= 1'b1;
                txd <= (k < hold) ? nibs[i][1:0] : nibs[i][3:2];
            end
        end
        @(posedge refClk);
        txEn <= 1'b0;
        txd <= idleVal;
    endtask : send_frame

    ////////////////////////////////////////////////////////////////////////////////
    // two quiet cycles in a row end the frame; a single low is the drain toggle
    always @(posedge refClk) begin
        prevDv <= crsDv;
        gotValid <= 1'b0;
        if (!inFrame) begin
            inFrame <= crsDv;
            started <= 1'b0;
            half <= 1'b0;
        end else if (!crsDv && !prevDv) begin
            inFrame <= 1'b0;
        end else if (started || rxd != 2'h0) begin
            started <= 1'b1;
            half <= !half;
            low <= rxd;
            if (half) begin
                gotNib <= {rxEr, rxd, low};
                gotValid <= 1'b1;
            end
        end
    end
endmodule : rmii_mac_model

// File: dv/rmii_phy_data_interface_test.sv
// self-checking bench of the device end of the reduced data interface
// assumes: design files and rmii_mac_model compiled before this file
module rmii_phy_data_interface_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic refClk = 1'b0;
    logic rst = 1'b1;
    logic speed100 = 1'b1;
    logic squelchPass = 1'b0;
    logic lineBit = 1'b1;
    logic lineBitValid = 1'b0;
    logic carrierEnd = 1'b0;
    logic rxNibValid = 1'b0;
    logic txNibReady = 1'b0;
    rmii_pkg::nibble_type rxNib = 5'h00;
    rmii_pkg::nibble_type txNib;
    logic txEn, crsDv, rxEr, rxNibReady, txNibValid, gotValid, txOverflow;
    logic sawOverflow = 1'b0;
    logic [1:0] txd;
    logic [1:0] rxd;
    logic [4:0] gotNib;
    logic [3:0] nibs[$];
    rmii_pkg::nibble_type rxExp[$];
    rmii_pkg::nibble_type txExp[$];
    int n_errors = 0;
    int samples_checked = 0;

    initial forever #5 clk = ~clk;
    initial begin
        #3;
        forever #6 refClk = ~refClk;
    end

    rmii_phy_data_interface dut (.clk(clk), .rst(rst), .referenceClockInput(refClk),
        .txEn(txEn), .txd(txd), .rxd(rxd), .crsDv(crsDv), .rxEr(rxEr),
        .speed100(speed100), .squelchPass(squelchPass), .lineBit(lineBit),
        .lineBitValid(lineBitValid), .carrierEnd(carrierEnd), .rxNibValid(rxNibValid),
        .rxNib(rxNib), .rxNibReady(rxNibReady), .txNibValid(txNibValid), .txNib(txNib),
        .txNibReady(txNibReady), .txOverflow(txOverflow));
    rmii_mac_model mac (.refClk(refClk), .txEn(txEn), .txd(txd), .rxd(rxd),
        .crsDv(crsDv), .rxEr(rxEr), .gotValid(gotValid), .gotNib(gotNib));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_nib(input rmii_pkg::nibble_type exp, input rmii_pkg::nibble_type got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : check_nib

    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : check_bit

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic line_bits(input logic [9:0] bits);
        for (int i = 9; i >= 0; i--) begin
            @(negedge clk);
            lineBit = bits[i];
            lineBitValid = 1'b1;
        end
        @(negedge clk);
        lineBitValid = 1'b0;
    endtask : line_bits

    task automatic pulse_end();
        @(negedge clk);
        carrierEnd = 1'b1;
        @(negedge clk);
        carrierEnd = 1'b0;
    endtask : pulse_end

    // low data bit forced to 1 so the first di-bit is never the idle code
    task automatic push_nibs(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            rxNibValid = 1'b1;
            rxNib = {1'($urandom), 3'($urandom), 1'b1};
            do @(posedge clk); while (rxNibReady !== 1'b1);
            rxExp.push_back(rxNib);
        end
        @(negedge clk);
        rxNibValid = 1'b0;
    endtask : push_nibs

    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) txNibReady <= ($urandom % 4) != 0;
    // the fifo is deep enough for these frames, so no nibble may be lost
    always @(posedge clk)
        if (txOverflow === 1'b1)
            sawOverflow <= 1'b1;
    always @(posedge clk)
        if (txNibValid === 1'b1 && txNibReady === 1'b1)
            check_nib(txExp.size() > 0 ? txExp.pop_front() : 5'hX, txNib);
    always @(posedge refClk)
        if (gotValid === 1'b1)
            check_nib(rxExp.size() > 0 ? rxExp.pop_front() : 5'hX, gotNib);

    initial begin
        #200us;
        n_errors++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(60));
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        for (int f = 0; f < 3; f++) begin
            if (f == 2) begin
                speed100 = 1'b0;
                repeat (10) @(negedge clk);
            end
            nibs = {};
            for (int i = 0; i < 6; i++) begin
                nibs.push_back(4'($urandom));
                txExp.push_back({i == 0, nibs[i]});
            end
            mac.send_frame(nibs, speed100 ? 1 : 10, 2'h3);
        end
        for (int t = 0; t < 3000 && txExp.size() > 0; t++) @(negedge clk);
        check_bit(txExp.size() == 0, 1'b1);
        check_bit(sawOverflow, 1'b0);
        $display("test transmit done");
        squelchPass = 1'b1;
        repeat (3) begin
            repeat (20) @(negedge clk);
            check_bit(crsDv, 1'b1);
        end
        squelchPass = 1'b0;
        repeat (60) @(negedge clk);
        check_bit(crsDv, 1'b0);
        speed100 = 1'b1;
        line_bits(10'h39F);
        repeat (20) @(negedge clk);
        check_bit(crsDv, 1'b0);
        pulse_end();
        $display("test carrier done");
        fork
            push_nibs(12);
            begin
                repeat (80) @(negedge clk);
                check_bit(rxNibReady, 1'b0);
                line_bits(10'h2BF);
                repeat (15) @(negedge clk);
                pulse_end();
            end
        join
        for (int t = 0; t < 3000 && rxExp.size() > 0; t++) @(negedge clk);
        check_bit(rxExp.size() == 0, 1'b1);
        repeat (20) @(negedge clk);
        check_bit(crsDv, 1'b0);
        $display("test receive done");
        tally_and_finish();
    end
endmodule : rmii_phy_data_interface_test

// File: rtl/rmii_async_fifo.sv
// dual-clock fifo with gray pointers
// assumes: each reset is synchronous to its own clock
module rmii_async_fifo #(
    parameter int WIDTH = 5,
    parameter int ADDR = 3
) (
    input wire logic writeClk,
    input wire logic writeRst,
    input wire logic writeValid,
    input wire logic [WIDTH-1:0] writeData,
    output logic writeReady,
    input wire logic readClk,
    input wire logic readRst,
    output logic readValid,
    output logic [WIDTH-1:0] readData,
    input wire logic readReady
);
    localparam int PTR = ADDR + 1;

    logic [WIDTH-1:0] mem [2**ADDR];
    logic [PTR-1:0] wBin, wGray, rBin, rGray;
    logic [PTR-1:0] rMeta, rMid, rLate, rHeld;
    logic [PTR-1:0] wMeta, wMid, wLate, wHeld;

    wire [PTR-1:0] wBinNext = wBin + PTR'(1);
    wire [PTR-1:0] rBinNext = rBin + PTR'(1);
    wire [PTR-1:0] fullGray = {~rHeld[PTR-1:PTR-2], rHeld[PTR-3:0]};
    wire writeFire = writeValid & writeReady;
    wire readFire = readValid & readReady;

    assign writeReady = wGray != fullGray;
    assign readValid = rGray != wHeld;
    assign readData = mem[rBin[ADDR-1:0]];

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge writeClk) begin
        if (writeFire) begin
            mem[wBin[ADDR-1:0]] <= writeData;
        end
    end

    // a pointer counts once the second and third stages agree
    always_ff @(posedge writeClk) begin
        rMeta <= rGray;
        rMid <= rMeta;
        rLate <= rMid;
        if (writeRst) begin
            wBin <= '0;
            wGray <= '0;
            rHeld <= '0;
        end else begin
            if (writeFire) begin
                wBin <= wBinNext;
                wGray <= wBinNext ^ (wBinNext >> 1);
            end
            if (rMid == rLate) begin
                rHeld <= rLate;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge readClk) begin
        wMeta <= wGray;
        wMid <= wMeta;
        wLate <= wMid;
        if (readRst) begin
            rBin <= '0;
            rGray <= '0;
            wHeld <= '0;
        end else begin
            if (readFire) begin
                rBin <= rBinNext;
                rGray <= rBinNext ^ (rBinNext >> 1);
            end
            if (wMid == wLate) begin
                wHeld <= wLate;
            end
        end
    end
endmodule : rmii_async_fifo

// File: rtl/rmii_phy_data_interface.sv
// device end of the reduced media-independent data interface
// assumes: core side on clk; pins timed to referenceClockInput
//
// What this block does
// - each cycle with TX_EN high, TXD is taken as transmit data (only every tenth cycle at 10 Mb/s)
// - TXD idles at 00 while TX_EN is low; device ignores it then
// - CRS_DV rises as soon as carrier is seen, not waiting for a nibble
// - carrier: squelch at 10 Mb/s, two non-adjacent zeroes in ten bits at 100
// - on carrier loss CRS_DV falls only with the first di-bit of a nibble
// - buffered bits after carrier: CRS_DV low on first, high on second di-bit
// - during false carrier CRS_DV stays high for the whole carrier
// - RXD shows 00 after CRS_DV rises until decoded data is available
// - RXD changes on clock edges, two data bits each cycle CRS_DV is high at 100 Mb/s, every tenth cycle at 10
// - RXD is 00 while CRS_DV is low, except first di-bits sent while draining after carrier; MAC ignores other values
// - RX_ER goes high synchronously for cycles of a frame with an error
// - transmit and receive paths independent, two bits wide, 10 and 100 Mb/s
`include "rmii_regs.svh"

module rmii_phy_data_interface (
    input wire logic clk,
    input wire logic rst,
    input wire logic referenceClockInput,
    input wire logic txEn,
    input wire logic [1:0] txd,
    output logic [1:0] rxd,
    output logic crsDv,
    output logic rxEr,
    input wire logic speed100,
    input wire logic squelchPass,
    input wire logic lineBit,
    input wire logic lineBitValid,
    input wire logic carrierEnd,
    input wire logic rxNibValid,
    input wire rmii_pkg::nibble_type rxNib,
    output logic rxNibReady,
    output logic txNibValid,
    output rmii_pkg::nibble_type txNib,
    input wire logic txNibReady,
    output logic txOverflow
);

    ////////////////////////////////////////////////////////////////////
    // carrier detection on the core clock
    logic [`LINE_WINDOW_BITS-1:0] lineWindow;
    logic [`LINE_WINDOW_BITS-1:0] zeroAbove;
    logic carrier;

    wire [`LINE_WINDOW_BITS-1:0] lineZero = ~lineWindow;

    assign zeroAbove[`LINE_WINDOW_BITS-1] = lineZero[`LINE_WINDOW_BITS-1];
    genvar bitIdx;
    generate
        for (bitIdx = 0; bitIdx < `LINE_WINDOW_BITS - 1; bitIdx++) begin : g_zero_above
            assign zeroAbove[bitIdx] = lineZero[bitIdx] | zeroAbove[bitIdx + 1];
        end
    endgenerate

    // a zero with another zero at least two places above it
    wire zeroPair = |(lineZero[`LINE_WINDOW_BITS-3:0] & zeroAbove[`LINE_WINDOW_BITS-1:2]);
    wire fastCarrier = carrier ? ~carrierEnd : zeroPair;
    wire next_carrier = speed100 ? fastCarrier : squelchPass;

    // the window is flushed at carrier end, else the last frame's
    // zeroes would raise carrier again at once
    always_ff @(posedge clk) begin
        if (rst || carrierEnd) begin
            lineWindow <= `LINE_IDLE_WINDOW;
        end else if (lineBitValid) begin
            lineWindow <= {lineWindow[`LINE_WINDOW_BITS-2:0], lineBit};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            carrier <= 1'b0;
        end else begin
            carrier <= next_carrier;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // two-entry buffer ahead of the receive crossing
    rmii_pkg::nibble_type skidMem [2];
    logic skidWrite;
    logic skidRead;
    logic [1:0] skidCount;
    logic rxFifoReady;

    wire skidPush = rxNibValid & rxNibReady;
    wire skidHas = skidCount != 2'h0;
    wire skidPop = skidHas & rxFifoReady;
    wire [1:0] next_skidCount = skidCount + {1'b0, skidPush} - {1'b0, skidPop};

    always_ff @(posedge clk) begin
        if (rst) begin
            skidCount <= 2'h0;
            skidWrite <= 1'b0;
            skidRead <= 1'b0;
            rxNibReady <= 1'b1;
        end else begin
            skidCount <= next_skidCount;
            skidWrite <= skidWrite ^ skidPush;
            skidRead <= skidRead ^ skidPop;
            rxNibReady <= next_skidCount != `SKID_DEPTH;
        end
    end

    always_ff @(posedge clk) begin
        if (skidPush) begin
            skidMem[skidWrite] <= rxNib;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // level crossing into the link domain, reset included
    logic [2:0] levelMeta;
    logic [2:0] levelMid;
    logic [2:0] levelLate;
    logic [2:0] levelHeld;

    wire [2:0] levelAgree = ~(levelMid ^ levelLate);
    wire linkRst = levelHeld[2];
    wire linkSpeed = levelHeld[1];
    wire linkCarrier = levelHeld[0];

    // the reference clock runs free, so the held levels keep pace
    always_ff @(posedge referenceClockInput) begin
        levelMeta <= {rst, speed100, carrier};
        levelMid <= levelMeta;
        levelLate <= levelMid;
        levelHeld <= (levelHeld & ~levelAgree) | (levelLate & levelAgree);
    end

    ////////////////////////////////////////////////////////////////////
    // word crossings
    logic rxWordValid;
    rmii_pkg::nibble_type rxWord;
    logic rxWordPop;
    logic txFifoReady;
    logic txFifoValid;
    rmii_pkg::nibble_type txFifoWord;
    rmii_pkg::nibble_type txWord;
    logic txPush;
    logic txTake;

    rmii_async_fifo #(
        .WIDTH($bits(rmii_pkg::nibble_type)),
        .ADDR(`FIFO_ADDR_BITS)
    ) u_rx_fifo (
        .writeClk(clk),
        .writeRst(rst),
        .writeValid(skidHas),
        .writeData(skidMem[skidRead]),
        .writeReady(rxFifoReady),
        .readClk(referenceClockInput),
        .readRst(linkRst),
        .readValid(rxWordValid),
        .readData(rxWord),
        .readReady(rxWordPop)
    );

    rmii_async_fifo #(
        .WIDTH($bits(rmii_pkg::nibble_type)),
        .ADDR(`FIFO_ADDR_BITS)
    ) u_tx_fifo (
        .writeClk(referenceClockInput),
        .writeRst(linkRst),
        .writeValid(txPush),
        .writeData(txWord),
        .writeReady(txFifoReady),
        .readClk(clk),
        .readRst(rst),
        .readValid(txFifoValid),
        .readData(txFifoWord),
        .readReady(txTake)
    );

    ////////////////////////////////////////////////////////////////////
    // transmit nibbles out to the core
    assign txTake = txFifoValid & (~txNibValid | txNibReady);

    always_ff @(posedge clk) begin
        if (rst) begin
            txNibValid <= 1'b0;
            txNib <= '0;
        end else if (txTake) begin
            txNibValid <= 1'b1;
            txNib <= txFifoWord;
        end else if (txNibReady) begin
            txNibValid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receive di-bit timing and carrier/data-valid sequencing
    rmii_pkg::rx_state_type rxState;
    rmii_pkg::rx_state_type next_rxState;
    logic [3:0] rxDiv;
    logic rxHalf;
    logic [1:0] rxUpper;
    logic [1:0] next_rxd;
    logic next_crsDv;
    logic next_rxEr;
    logic next_rxHalf;

    wire rxDivEnd = rxDiv == `SLOW_DIBIT_CYCLES - 4'h1;
    wire rxTick = linkSpeed | rxDivEnd;
    wire firstSlot = rxTick & ~rxHalf;
    wire secondSlot = rxTick & rxHalf;
    wire rxActive = rxState != rmii_pkg::RX_IDLE;
    assign rxWordPop = firstSlot & rxWordValid & rxActive;

    always_comb begin
        next_rxState = rxState;
        next_rxd = rxd;
        next_crsDv = crsDv;
        next_rxEr = rxEr;
        next_rxHalf = rxHalf;
        case (rxState)
            rmii_pkg::RX_IDLE: begin
                // raised off the di-bit grid to keep latency short
                if (linkCarrier) begin
                    next_crsDv = 1'b1;
                    next_rxState = rmii_pkg::RX_WAIT;
                end
            end
            rmii_pkg::RX_WAIT: begin
                if (rxWordPop) begin
                    next_rxd = rxWord.data[1:0];
                    next_rxEr = rxWord.flag;
                    next_rxHalf = 1'b1;
                    next_rxState = rmii_pkg::RX_DELIVER;
                end else if (firstSlot && !linkCarrier) begin
                    next_crsDv = 1'b0;
                    next_rxState = rmii_pkg::RX_IDLE;
                end
            end
            rmii_pkg::RX_DELIVER: begin
                if (secondSlot) begin
                    next_rxd = rxUpper;
                    next_rxHalf = 1'b0;
                    next_crsDv = 1'b1;
                end else if (rxWordPop) begin
                    next_rxd = rxWord.data[1:0];
                    next_rxEr = rxWord.flag;
                    next_rxHalf = 1'b1;
                    next_crsDv = linkCarrier;
                end else if (firstSlot) begin
                    // underrun or end of data: idle di-bits
                    next_rxd = `IDLE_DIBIT;
                    next_rxEr = 1'b0;
                    next_crsDv = linkCarrier;
                    if (!linkCarrier) begin
                        next_rxState = rmii_pkg::RX_IDLE;
                    end
                end
            end
            default: begin
                next_rxState = rmii_pkg::RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge referenceClockInput) begin
        if (linkRst || rxTick) begin
            rxDiv <= `DIV_ZERO;
        end else begin
            rxDiv <= rxDiv + 4'h1;
        end
    end

    always_ff @(posedge referenceClockInput) begin
        if (linkRst) begin
            rxState <= rmii_pkg::RX_IDLE;
            rxd <= `IDLE_DIBIT;
            crsDv <= 1'b0;
            rxEr <= 1'b0;
            rxHalf <= 1'b0;
        end else begin
            rxState <= next_rxState;
            rxd <= next_rxd;
            crsDv <= next_crsDv;
            rxEr <= next_rxEr;
            rxHalf <= next_rxHalf;
        end
    end

    always_ff @(posedge referenceClockInput) begin
        if (rxWordPop) begin
            rxUpper <= rxWord.data[3:2];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit di-bit capture; pins are already on this clock
    logic [3:0] txDiv;
    logic txHalf;
    logic [1:0] txLow;
    logic txStart;
    logic overflowToggle;

    wire txDivEnd = txDiv == `SLOW_DIBIT_CYCLES - 4'h1;
    wire txSlot = linkSpeed | (txDiv == `DIV_ZERO);
    wire txSample = txEn & txSlot;
    assign txPush = txSample & txHalf;
    assign txWord = '{flag: txStart, data: {txd, txLow}};
    // the MAC cannot be stalled: a full fifo loses the nibble
    wire txLost = txPush & ~txFifoReady;

    // the 10 Mb/s grid restarts with each frame's first di-bit
    always_ff @(posedge referenceClockInput) begin
        if (linkRst || !txEn || txDivEnd) begin
            txDiv <= `DIV_ZERO;
        end else begin
            txDiv <= txDiv + 4'h1;
        end
    end

    always_ff @(posedge referenceClockInput) begin
        if (linkRst || !txEn) begin
            txHalf <= 1'b0;
            txStart <= 1'b1;
        end else begin
            txHalf <= txHalf ^ txSample;
            txStart <= txStart & ~txPush;
        end
    end

    always_ff @(posedge referenceClockInput) begin
        if (txSample && !txHalf) begin
            txLow <= txd;
        end
    end

    always_ff @(posedge referenceClockInput) begin
        if (linkRst) begin
            overflowToggle <= 1'b0;
        end else begin
            overflowToggle <= overflowToggle ^ txLost;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // overflow event back to the core clock
    logic ovMeta;
    logic ovMid;
    logic ovLate;
    logic ovSeen;

    wire ovNew = (ovMid == ovLate) & (ovLate != ovSeen);

    always_ff @(posedge clk) begin
        ovMeta <= overflowToggle;
        ovMid <= ovMeta;
        ovLate <= ovMid;
        if (rst) begin
            ovSeen <= 1'b0;
            txOverflow <= 1'b0;
        end else begin
            ovSeen <= ovNew ? ovLate : ovSeen;
            txOverflow <= ovNew;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    a_carrier_detect: assert property (@(posedge clk) disable iff (rst)
        speed100 && !carrier && zeroPair |=> carrier)
        else $error("two spaced zeroes did not raise carrier");

    a_crs_rise: assert property (@(posedge referenceClockInput) disable iff (linkRst)
        rxState == rmii_pkg::RX_IDLE && linkCarrier |=> crsDv && !rxHalf)
        else $error("crs_dv late after carrier");

    a_crs_boundary: assert property (@(posedge referenceClockInput) disable iff (linkRst)
        $fell(crsDv) |-> $past(rxTick) && (rxHalf || rxState == rmii_pkg::RX_IDLE))
        else $error("crs_dv fell off a nibble boundary");

    a_crs_toggle: assert property (@(posedge referenceClockInput) disable iff (linkRst)
        $rose(crsDv) && $past(rxState) == rmii_pkg::RX_DELIVER |-> !rxHalf && $past(rxTick))
        else $error("crs_dv rose on a first di-bit");

    a_false_carrier: assert property (@(posedge referenceClockInput) disable iff (linkRst)
        crsDv && linkCarrier |=> crsDv)
        else $error("crs_dv dropped during carrier");

    a_wait_zero: assert property (@(posedge referenceClockInput) disable iff (linkRst)
        rxState == rmii_pkg::RX_WAIT |-> rxd == `IDLE_DIBIT)
        else $error("rxd not idle before decoded data");

    a_rxd_load: assert property (@(posedge referenceClockInput) disable iff (linkRst)
        rxWordPop |=> rxd == $past(rxWord.data[1:0]) ##1 rxHalf || rxd == $past(rxUpper))
        else $error("rxd lost the popped nibble");

    a_idle_quiet: assert property (@(posedge referenceClockInput) disable iff (linkRst)
        rxState == rmii_pkg::RX_IDLE |-> !crsDv && !rxEr && rxd == `IDLE_DIBIT)
        else $error("receive pins busy while idle");

    a_error_frame: assert property (@(posedge referenceClockInput) disable iff (linkRst)
        rxEr |-> rxState == rmii_pkg::RX_DELIVER)
        else $error("rx_er outside a frame");

    a_dibit_hold: assert property (@(posedge referenceClockInput) disable iff (linkRst)
        $changed(rxd) |-> $past(rxTick))
        else $error("rxd moved between di-bit slots");

    a_tx_take: assert property (@(posedge referenceClockInput) disable iff (linkRst)
        ($rose(txEn) && linkSpeed) ##1 (txEn && linkSpeed) |-> txPush)
        else $error("second di-bit did not complete a nibble");

    a_tx_idle: assert property (@(posedge referenceClockInput) disable iff (linkRst)
        !txEn ##1 (txEn && linkSpeed) |-> !txPush)
        else $error("idle di-bit counted as data");

    a_tx_order: assert property (@(posedge referenceClockInput) disable iff (linkRst)
        txPush && linkSpeed && $past(txSample) |-> txWord.data == {txd, $past(txd)})
        else $error("transmit di-bits paired in wrong order");

    c_crs_toggle: cover property (@(posedge referenceClockInput) disable iff (linkRst)
        rxState == rmii_pkg::RX_DELIVER && !linkCarrier && $rose(crsDv));

    c_tx_frame: cover property (@(posedge referenceClockInput) disable iff (linkRst)
        txPush && txWord.flag);

    c_rx_error: cover property (@(posedge referenceClockInput) disable iff (linkRst)
        rxEr && crsDv);

    c_skid_full: cover property (@(posedge clk) disable iff (rst)
        skidCount == `SKID_DEPTH && rxNibValid);
endmodule : rmii_phy_data_interface

// File: rtl/rmii_pkg.sv
// types shared by the reduced data interface and its fifo
// assumes: nothing beyond the compiler
package rmii_pkg;
    // flag is the error mark on receive, the frame start on transmit
    typedef struct packed {
        logic flag;
        logic [3:0] data;
    } nibble_type;

    typedef enum logic [1:0] {RX_IDLE, RX_WAIT, RX_DELIVER} rx_state_type;
endpackage : rmii_pkg

// File: rtl/rmii_regs.svh
// timing and idle values of the reduced data interface
// assumes: included by bare name; holds definitions only
`ifndef RMII_REGS_SVH
`define RMII_REGS_SVH

// reference clock cycles that one di-bit stands at 10 Mb/s
`define SLOW_DIBIT_CYCLES 4'hA
`define DIV_ZERO 4'h0
// idle value of a di-bit on either data path
`define IDLE_DIBIT 2'h0
// received code bits watched for carrier at 100 Mb/s
`define LINE_WINDOW_BITS 10
`define LINE_IDLE_WINDOW 10'h3FF
// address bits of each clock-crossing fifo (eight words)
`define FIFO_ADDR_BITS 3
`define SKID_DEPTH 2'h2

`endif
